/* cpu_regfile_wide_access_guard.sv */
// Function
// - thirty-two eight-bit working registers, apart from data memory.
// - register file accesses complete within one clock cycle.
// - immediate-class instructions reach only registers sixteen to thirty-one.
// - registers twenty-six to thirty-one form three address pointers; last is program pointer.
// - lower index is low byte, higher index is high byte.
// - pointers support displacement, post-increment and pre-decrement.
// - low-byte write of wide register goes to shadow byte only.
// - high-byte write copies shadow into low byte same cycle.
// - low-byte read captures high byte into shadow same cycle.
// - high-byte read returns the shadow byte.
// - protected writes and self-programming blocked until signature written.
// - two unlock modes: protected registers and self-programming.
// - io window closes on memory write, nonvolatile access or sleep.
// - program window lasts four instructions, closes on nonvolatile access or sleep.
// - interrupts held pending while any window is open.
// - pending interrupts served once the window ends.
// - signature D8 opens the protected register window.
// - signature 9D opens the self-programming window.
// - guard reads bit0 io window, bit1 program window, rest zero.
// Purpose: working register file, wide register shadow byte, access guard
// Assumes: register port with read data one cycle after the strobe
// Notes: explicit register write beats pointer update on the same entry
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
module cpu_regfile_wide_access_guard #(
  parameter logic [15:0] STACK_TOP_RESET = 16'h00FF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire regfile_guard_pkg::rf_write_t rf_wr,
  input wire logic [4:0] rd_a_idx,
  input wire logic rd_a_imm_op,
  input wire logic [4:0] rd_b_idx,
  output logic [7:0] rd_a_data,
  output logic [7:0] rd_b_data,
  input wire regfile_guard_pkg::ptr_req_t ptr_req,
  output logic [15:0] ptr_addr,
  output logic [15:0] prog_ptr_addr,
  input wire regfile_guard_pkg::cpu_event_t cpu_ev,
  output logic protected_io_unlock,
  output logic self_program_unlock,
  output logic irq_hold,
  output logic [7:0] prot_cfg
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] rf_reg [regfile_guard_pkg::RF_ENTRIES];
  logic [15:0] wide_reg;
  logic [7:0] shadow_reg;
  logic [15:0] stack_top_pointer_reg;
  logic [7:0] result_flags_reg;
  logic [7:0] rdata_next;
  logic [4:0] wr_idx;
  logic [4:0] rd_a_eff;
  logic [4:0] ptr_lo_idx;
  logic [4:0] ptr_hi_idx;
  logic [15:0] ptr_cur;
  logic [15:0] ptr_new;
  logic [15:0] ptr_eff;
  logic ptr_upd;
  logic guard_wr;
  logic other_io_wr;

  assign wr_idx = rf_wr.imm_op ? {1'b1, rf_wr.idx[3:0]} : rf_wr.idx;
  assign rd_a_eff = rd_a_imm_op ? {1'b1, rd_a_idx[3:0]} : rd_a_idx;

  // ---------------------------------------------------------------
  // pointer pairs
  // ---------------------------------------------------------------
  // pair select
  assign ptr_lo_idx = regfile_guard_pkg::FIRST_POINTER_IDX + {2'b00, ptr_req.sel, 1'b0};
  assign ptr_hi_idx = ptr_lo_idx | 5'h01;
  assign ptr_cur = {rf_reg[ptr_hi_idx], rf_reg[ptr_lo_idx]};
  assign ptr_upd = ptr_req.valid && ptr_req.mode != regfile_guard_pkg::PTR_DISP;

  always_comb begin
    ptr_new = ptr_cur;
    ptr_eff = ptr_cur;
    unique case (ptr_req.mode)
      regfile_guard_pkg::PTR_DISP: begin
        ptr_eff = ptr_cur + {10'h000, ptr_req.disp};
      end
      regfile_guard_pkg::PTR_POST_INC: begin
        ptr_new = ptr_cur + 16'h0001;
      end
      regfile_guard_pkg::PTR_PRE_DEC: begin
        ptr_new = ptr_cur - 16'h0001;
        ptr_eff = ptr_new;
      end
      default: begin
        ptr_eff = ptr_cur;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_addr <= 16'h0000;
    end else if (ptr_req.valid) begin
      ptr_addr <= ptr_eff;
    end
  end

  // ---------------------------------------------------------------
  // register file entries
  // ---------------------------------------------------------------
  // thirty-two byte entries
  for (genvar i = 0; i < regfile_guard_pkg::RF_ENTRIES; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (rst) begin
        rf_reg[i] <= 8'h00;
      end else if (rf_wr.en && wr_idx == 5'(i)) begin
        rf_reg[i] <= rf_wr.data;
      end else if (ptr_upd && ptr_lo_idx == 5'(i)) begin
        rf_reg[i] <= ptr_new[7:0];
      end else if (ptr_upd && ptr_hi_idx == 5'(i)) begin
        rf_reg[i] <= ptr_new[15:8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_a_data <= 8'h00;
      rd_b_data <= 8'h00;
    end else begin
      rd_a_data <= rf_reg[rd_a_eff];
      rd_b_data <= rf_reg[rd_b_idx];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prog_ptr_addr <= 16'h0000;
    end else begin
      prog_ptr_addr <= {rf_reg[regfile_guard_pkg::LAST_WORKING_IDX], rf_reg[regfile_guard_pkg::PTR_C_LOW_IDX]};
    end
  end

  // ---------------------------------------------------------------
  // wide register with shadow byte
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      shadow_reg <= regfile_guard_pkg::SHADOW_RESET;
    end else if (reg_wr && reg_addr == regfile_guard_pkg::WIDE_LOW_OFS) begin
      shadow_reg <= reg_wdata;
    end else if (reg_rd && reg_addr == regfile_guard_pkg::WIDE_LOW_OFS) begin
      shadow_reg <= wide_reg[15:8];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wide_reg <= regfile_guard_pkg::WIDE_RESET;
    end else if (reg_wr && reg_addr == regfile_guard_pkg::WIDE_HIGH_OFS) begin
      wide_reg <= {reg_wdata, shadow_reg};
    end else if (prot_cfg[regfile_guard_pkg::PROT_RUN_BIT]) begin
      wide_reg <= wide_reg + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // plain registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      stack_top_pointer_reg <= STACK_TOP_RESET;
      result_flags_reg <= regfile_guard_pkg::FLAGS_RESET;
    end else if (reg_wr) begin
      if (reg_addr == regfile_guard_pkg::STACK_TOP_LOW_OFS) begin
        stack_top_pointer_reg[7:0] <= reg_wdata;
      end
      if (reg_addr == regfile_guard_pkg::STACK_TOP_HIGH_OFS) begin
        stack_top_pointer_reg[15:8] <= reg_wdata;
      end
      if (reg_addr == regfile_guard_pkg::FLAGS_OFS) begin
        result_flags_reg <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prot_cfg <= regfile_guard_pkg::PROT_CFG_RESET;
    end else if (reg_wr && reg_addr == regfile_guard_pkg::PROT_CFG_OFS && protected_io_unlock
                 && reg_wdata[regfile_guard_pkg::PROT_CHANGE_EN_BIT]) begin
      prot_cfg <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // access guard
  // ---------------------------------------------------------------
  assign guard_wr = reg_wr && reg_addr == regfile_guard_pkg::GUARD_OFS;
  assign other_io_wr = reg_wr && !guard_wr;

  change_guard i_change_guard (
    .clk(clk),
    .rst(rst),
    .sig_wr(guard_wr),
    .sig_data(reg_wdata),
    .io_write(other_io_wr),
    .ev(cpu_ev),
    .io_unlock(protected_io_unlock),
    .prog_unlock(self_program_unlock),
    .irq_hold(irq_hold)
  );

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    unique case (reg_addr)
      regfile_guard_pkg::GUARD_OFS: rdata_next = {6'h00, self_program_unlock, protected_io_unlock};
      regfile_guard_pkg::STACK_TOP_LOW_OFS: rdata_next = stack_top_pointer_reg[7:0];
      regfile_guard_pkg::STACK_TOP_HIGH_OFS: rdata_next = stack_top_pointer_reg[15:8];
      regfile_guard_pkg::FLAGS_OFS: rdata_next = result_flags_reg;
      regfile_guard_pkg::WIDE_LOW_OFS: rdata_next = wide_reg[7:0];
      regfile_guard_pkg::WIDE_HIGH_OFS: rdata_next = shadow_reg;
      regfile_guard_pkg::PROT_CFG_OFS: rdata_next = prot_cfg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rdata_next : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence low_read_s;
    reg_rd && reg_addr == regfile_guard_pkg::WIDE_LOW_OFS;
  endsequence
  chk_low_read_capture: assert property (
    low_read_s |=> shadow_reg == $past(wide_reg[15:8]))
    else $error("low read did not capture high byte");
  chk_high_read_shadow: assert property (
    reg_rd && reg_addr == regfile_guard_pkg::WIDE_HIGH_OFS |=> reg_rdata == $past(shadow_reg))
    else $error("high read not from shadow");
  chk_low_write_held: assert property (
    reg_wr && reg_addr == regfile_guard_pkg::WIDE_LOW_OFS && !prot_cfg[regfile_guard_pkg::PROT_RUN_BIT]
    |=> $stable(wide_reg[7:0]) && shadow_reg == $past(reg_wdata))
    else $error("low write reached live register");
  chk_high_write_pair: assert property (
    reg_wr && reg_addr == regfile_guard_pkg::WIDE_HIGH_OFS |=> wide_reg == {$past(reg_wdata), $past(shadow_reg)})
    else $error("wide write not paired");
  chk_imm_upper_half: assert property (
    rf_wr.en && rf_wr.imm_op && !ptr_req.valid |=> rf_reg[{1'b1, $past(rf_wr.idx[3:0])}] == $past(rf_wr.data))
    else $error("immediate write outside upper half");
  chk_ptr_post_inc: assert property (
    ptr_req.valid && ptr_req.mode == regfile_guard_pkg::PTR_POST_INC && !rf_wr.en
    |=> ptr_addr == $past(ptr_cur) && {rf_reg[$past(ptr_hi_idx)], rf_reg[$past(ptr_lo_idx)]} == $past(ptr_cur) + 16'h0001)
    else $error("post increment wrong");
  chk_guard_readback: assert property (
    reg_rd && reg_addr == regfile_guard_pkg::GUARD_OFS
    |=> reg_rdata == {6'h00, $past(self_program_unlock), $past(protected_io_unlock)})
    else $error("guard status read wrong");
  chk_prot_blocked: assert property (
    reg_wr && reg_addr == regfile_guard_pkg::PROT_CFG_OFS && !protected_io_unlock |=> $stable(prot_cfg))
    else $error("protected register changed while locked");
  chk_ptr_pre_dec: assert property (
    ptr_req.valid && ptr_req.mode == regfile_guard_pkg::PTR_PRE_DEC && !rf_wr.en
    |=> ptr_addr == $past(ptr_cur) - 16'h0001 && {rf_reg[$past(ptr_hi_idx)], rf_reg[$past(ptr_lo_idx)]} == ptr_addr)
    else $error("pre decrement wrong");
  chk_ptr_disp_hold: assert property (
    ptr_req.valid && ptr_req.mode == regfile_guard_pkg::PTR_DISP && !rf_wr.en
    |=> ptr_addr == $past(ptr_cur) + {10'h000, $past(ptr_req.disp)}
    && {rf_reg[$past(ptr_hi_idx)], rf_reg[$past(ptr_lo_idx)]} == $past(ptr_cur))
    else $error("displacement moved pointer");
endmodule : cpu_regfile_wide_access_guard

/* regfile_guard_pkg.sv */
// Purpose: shared constants and types for the register file and access guard
// Assumes: 8-bit register port, one clock
// Notes: offsets are byte addresses on the register port
package regfile_guard_pkg;
  // ---------------------------------------------------------------
  // register file shape
  // ---------------------------------------------------------------
  localparam int unsigned RF_ENTRIES = 32;
  localparam int unsigned RF_WIDTH = 8;
  localparam logic [4:0] FIRST_POINTER_IDX = 5'h1A;
  localparam logic [4:0] LAST_WORKING_IDX = 5'h1F;
  localparam logic [4:0] PTR_C_LOW_IDX = 5'h1E;
  localparam int unsigned UPPER_HALF_BIT = 4;
  // ---------------------------------------------------------------
  // register port offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] GUARD_OFS = 8'h04;
  localparam logic [7:0] STACK_TOP_LOW_OFS = 8'h0D;
  localparam logic [7:0] STACK_TOP_HIGH_OFS = 8'h0E;
  localparam logic [7:0] FLAGS_OFS = 8'h0F;
  localparam logic [7:0] WIDE_LOW_OFS = 8'h10;
  localparam logic [7:0] WIDE_HIGH_OFS = 8'h11;
  localparam logic [7:0] PROT_CFG_OFS = 8'h12;
  // ---------------------------------------------------------------
  // reset values and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] PROT_CFG_RESET = 8'h00;
  localparam logic [15:0] WIDE_RESET = 16'h0000;
  localparam logic [7:0] SHADOW_RESET = 8'h00;
  localparam int unsigned PROT_CHANGE_EN_BIT = 0;
  localparam int unsigned PROT_RUN_BIT = 1;
  localparam int unsigned GUARD_IO_BIT = 0;
  localparam int unsigned GUARD_PROG_BIT = 1;
  // ---------------------------------------------------------------
  // guard signatures and window
  // ---------------------------------------------------------------
  localparam logic [7:0] SIG_PROTECTED_IO = 8'hD8;
  localparam logic [7:0] SIG_SELF_PROGRAM = 8'h9D;
  localparam logic [2:0] WINDOW_INSNS = 3'h4;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    GUARD_CLOSED = 3'b001,
    GUARD_IO_OPEN = 3'b010,
    GUARD_PROG_OPEN = 3'b100
  } guard_state_t;
  typedef enum logic [1:0] {
    PTR_DISP = 2'h0,
    PTR_POST_INC = 2'h1,
    PTR_PRE_DEC = 2'h2
  } ptr_mode_t;
  typedef struct packed {
    logic valid;
    logic [1:0] sel;
    ptr_mode_t mode;
    logic [5:0] disp;
  } ptr_req_t;
  typedef struct packed {
    logic insn_retire;
    logic mem_write;
    logic nvm_access;
    logic sleep_exec;
  } cpu_event_t;
  typedef struct packed {
    logic en;
    logic imm_op;
    logic [4:0] idx;
    logic [7:0] data;
  } rf_write_t;
endpackage : regfile_guard_pkg

/* change_guard.sv */
// Purpose: unlock windows for protected registers and self-programming
// Assumes: one retire pulse per executed instruction
// Notes: signature write wins over a closing event in the same cycle
`timescale 1ns/10ps
module change_guard (
  input wire logic clk,
  input wire logic rst,
  input wire logic sig_wr,
  input wire logic [7:0] sig_data,
  input wire logic io_write,
  input wire regfile_guard_pkg::cpu_event_t ev,
  output logic io_unlock,
  output logic prog_unlock,
  output logic irq_hold
);
  // ---------------------------------------------------------------
  // window state
  // ---------------------------------------------------------------
  regfile_guard_pkg::guard_state_t state_reg;
  regfile_guard_pkg::guard_state_t state_next;
  logic [2:0] left_reg;
  logic [2:0] left_next;
  logic close_io;
  logic close_prog;

  assign close_io = io_write | sig_wr | ev.mem_write | ev.nvm_access | ev.sleep_exec;
  assign close_prog = ev.nvm_access | ev.sleep_exec;

  always_comb begin
    state_next = state_reg;
    left_next = left_reg;
    if (sig_wr && sig_data == regfile_guard_pkg::SIG_PROTECTED_IO) begin
      state_next = regfile_guard_pkg::GUARD_IO_OPEN;
      left_next = regfile_guard_pkg::WINDOW_INSNS;
    end else if (sig_wr && sig_data == regfile_guard_pkg::SIG_SELF_PROGRAM) begin
      state_next = regfile_guard_pkg::GUARD_PROG_OPEN;
      left_next = regfile_guard_pkg::WINDOW_INSNS;
    end else begin
      unique case (state_reg)
        regfile_guard_pkg::GUARD_CLOSED: begin
          left_next = 3'h0;
        end
        regfile_guard_pkg::GUARD_IO_OPEN: begin
          if (close_io || (ev.insn_retire && left_reg == 3'h1)) begin
            state_next = regfile_guard_pkg::GUARD_CLOSED;
          end
        end
        regfile_guard_pkg::GUARD_PROG_OPEN: begin
          if (close_prog || (ev.insn_retire && left_reg == 3'h1)) begin
            state_next = regfile_guard_pkg::GUARD_CLOSED;
          end
        end
        default: begin
          state_next = regfile_guard_pkg::GUARD_CLOSED;
        end
      endcase
      if (ev.insn_retire && left_reg != 3'h0) begin
        left_next = left_reg - 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= regfile_guard_pkg::GUARD_CLOSED;
      left_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      left_reg <= left_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      io_unlock <= 1'b0;
      prog_unlock <= 1'b0;
    end else begin
      io_unlock <= state_next == regfile_guard_pkg::GUARD_IO_OPEN;
      prog_unlock <= state_next == regfile_guard_pkg::GUARD_PROG_OPEN;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_hold <= 1'b0;
    end else begin
      irq_hold <= state_next != regfile_guard_pkg::GUARD_CLOSED;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence io_opened_s;
    sig_wr && sig_data == regfile_guard_pkg::SIG_PROTECTED_IO;
  endsequence
  sequence quiet_retire_s;
    ev.insn_retire && !close_io && !sig_wr;
  endsequence
  chk_io_window_len: assert property (@(posedge clk) disable iff (rst)
    io_opened_s ##1 quiet_retire_s [*4] |=> !io_unlock)
    else $error("io window outlived four instructions");
  chk_io_open_signature: assert property (@(posedge clk) disable iff (rst)
    io_opened_s |=> io_unlock && !prog_unlock)
    else $error("io signature did not open window");
  chk_prog_sleep_close: assert property (@(posedge clk) disable iff (rst)
    prog_unlock && ev.sleep_exec && !sig_wr |=> !prog_unlock)
    else $error("program window survived sleep");
  chk_irq_hold_tie: assert property (@(posedge clk) disable iff (rst)
    irq_hold == (io_unlock || prog_unlock))
    else $error("interrupt hold out of step with window");
endmodule : change_guard

/* core_event_model.sv */
// Purpose: core side model issuing retire and event pulses
// Assumes: one request cycle gives one event pulse
// Notes: pulses leave one cycle after the request
`timescale 1ns/10ps
module core_event_model (
  input wire logic clk,
  input wire logic rst,
  input wire regfile_guard_pkg::cpu_event_t req,
  output regfile_guard_pkg::cpu_event_t cpu_ev
);
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_ev <= '0;
    end else begin
      cpu_ev <= req;
    end
  end
endmodule : core_event_model

/* tb_cpu_regfile_wide_access_guard.sv */
// Purpose: self-checking bench for register file, shadow byte and guard
// Assumes: reg port read data one cycle after strobe
// Notes: no random stimulus
`timescale 1ns/10ps
module tb_cpu_regfile_wide_access_guard;
  // -------------------------------------------------
  // signals
  // -------------------------------------------------
  logic clk, rst, reg_wr, reg_rd, rd_a_imm_op;
  logic protected_io_unlock, self_program_unlock, irq_hold;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_a_data, rd_b_data, prot_cfg, v;
  logic [4:0] rd_a_idx, rd_b_idx;
  logic [15:0] ptr_addr, prog_ptr_addr;
  regfile_guard_pkg::rf_write_t rf_wr;
  regfile_guard_pkg::ptr_req_t ptr_req;
  regfile_guard_pkg::cpu_event_t ev_req, cpu_ev;
  int n_mismatch, checks;
  localparam logic [15:0] SP_INIT = 16'h0123;
  cpu_regfile_wide_access_guard #(.STACK_TOP_RESET(SP_INIT)) i_cpu_regfile_wide_access_guard (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rf_wr(rf_wr), .rd_a_idx(rd_a_idx),
    .rd_a_imm_op(rd_a_imm_op), .rd_b_idx(rd_b_idx), .rd_a_data(rd_a_data), .rd_b_data(rd_b_data),
    .ptr_req(ptr_req), .ptr_addr(ptr_addr), .prog_ptr_addr(prog_ptr_addr), .cpu_ev(cpu_ev),
    .protected_io_unlock(protected_io_unlock), .self_program_unlock(self_program_unlock),
    .irq_hold(irq_hold), .prot_cfg(prot_cfg)
  );
  core_event_model i_core_event_model (.clk(clk), .rst(rst), .req(ev_req), .cpu_ev(cpu_ev));
  // -------------------------------------------------
  // helpers
  // -------------------------------------------------
  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task ev(input logic [3:0] e);
    @(posedge clk);
    ev_req <= e;
    @(posedge clk);
    ev_req <= '0;
    repeat (2) @(posedge clk);
    #1;
  endtask : ev
  task rfw(input logic [4:0] idx, input logic [7:0] d, input logic imm);
    @(posedge clk);
    rf_wr <= '{1'b1, imm, idx, d};
    @(posedge clk);
    rf_wr <= '0;
  endtask : rfw
  task look(input logic [4:0] a, input logic [4:0] b, input logic imm);
    @(posedge clk);
    rd_a_idx <= a;
    rd_b_idx <= b;
    rd_a_imm_op <= imm;
    repeat (3) @(posedge clk);
    #1;
  endtask : look
  // -------------------------------------------------
  // scenarios
  // -------------------------------------------------
  task t_reset;
    rd(8'h04);
    chk("guard", v, 8'h00);
    rd(8'h0D);
    chk("sp_low", v, SP_INIT[7:0]);
    rd(8'h0E);
    chk("sp_high", v, SP_INIT[15:8]);
    rd(8'h00);
    chk("unmapped", v, 8'h00);
    wr(8'h0F, 8'h5A);
    rd(8'h0F);
    chk("flags", v, 8'h5A);
    $display("done reset");
  endtask : t_reset
  task t_wide;
    wr(8'h10, 8'h34);
    wr(8'h11, 8'h12);
    rd(8'h10);
    chk("wide_low", v, 8'h34);
    rd(8'h11);
    chk("wide_high", v, 8'h12);
    wr(8'h10, 8'h99);
    rd(8'h11);
    chk("shadow", v, 8'h99);
    rd(8'h10);
    chk("low_kept", v, 8'h34);
    rd(8'h11);
    chk("captured", v, 8'h12);
    wr(8'h10, 8'h78);
    rd(8'h11);
    wr(8'h10, 8'h00);
    wr(8'h11, 8'hAB);
    wr(8'h10, v);
    wr(8'h11, 8'h56);
    rd(8'h10);
    chk("restored", v, 8'h78);
    rd(8'h11);
    chk("restored_hi", v, 8'h56);
    $display("done wide");
  endtask : t_wide
  task t_guard;
    logic [7:0] sig [10] = '{8'hD8, 8'hD8, 8'hD8, 8'hD8, 8'hD8, 8'h9D, 8'h9D, 8'h9D, 8'h9D, 8'h9D};
    logic [3:0] evt [10] = '{4'h8, 4'h8, 4'h4, 4'h2, 4'h1, 4'h8, 4'h8, 4'h4, 4'h2, 4'h1};
    int cnt [10] = '{3, 4, 1, 1, 1, 3, 4, 1, 1, 1};
    logic [1:0] exp [10] = '{2'b10, 2'b00, 2'b00, 2'b00, 2'b00, 2'b01, 2'b00, 2'b01, 2'b00, 2'b00};
    wr(8'h12, 8'h01);
    chk("locked", prot_cfg, 8'h00);
    wr(8'h04, 8'h55);
    rd(8'h04);
    chk("bad_sig", v, 8'h00);
    wr(8'h04, 8'hD8);
    rd(8'h04);
    chk("io_bit", v, 8'h01);
    chk("io_hold", irq_hold, 1'b1);
    wr(8'h12, 8'h01);
    chk("prot_cfg", prot_cfg, 8'h01);
    chk("io_closed", protected_io_unlock, 1'b0);
    chk("hold_end", irq_hold, 1'b0);
    wr(8'h04, 8'h9D);
    rd(8'h04);
    chk("prog_bit", v, 8'h02);
    chk("prog_open", self_program_unlock, 1'b1);
    for (int i = 0; i < 10; i++) begin
      wr(8'h04, sig[i]);
      repeat (cnt[i]) ev(evt[i]);
      chk("window", {protected_io_unlock, self_program_unlock}, exp[i]);
      chk("hold", irq_hold, |exp[i]);
    end
    wr(8'h04, 8'hD8);
    wr(8'h04, 8'h55);
    chk("bad_close", protected_io_unlock, 1'b0);
    wr(8'h10, 8'hFE);
    wr(8'h11, 8'h12);
    wr(8'h04, 8'hD8);
    wr(8'h12, 8'h03);
    rd(8'h10);
    chk("run_low", v, 8'hFF);
    rd(8'h11);
    chk("run_high", v, 8'h12);
    wr(8'h04, 8'hD8);
    wr(8'h12, 8'h01);
    $display("done guard");
  endtask : t_guard
  task t_burst;
    @(posedge clk);
    reg_addr <= 8'h04;
    reg_wdata <= 8'hD8;
    reg_wr <= 1'b1;
    ev_req <= 4'h8;
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (3) @(posedge clk);
    ev_req <= '0;
    #1 chk("burst_open", protected_io_unlock, 1'b1);
    @(posedge clk);
    #1 chk("burst_shut", protected_io_unlock, 1'b0);
    $display("done burst");
  endtask : t_burst
  task t_regs;
    rfw(5'h05, 8'hA5, 1'b0);
    rfw(5'h05, 8'h5A, 1'b1);
    look(5'h05, 5'h15, 1'b0);
    chk("plain", rd_a_data, 8'hA5);
    chk("upper", rd_b_data, 8'h5A);
    look(5'h05, 5'h15, 1'b1);
    chk("imm_read", rd_a_data, 8'h5A);
    rfw(5'h1A, 8'hFF, 1'b0);
    rfw(5'h1B, 8'h01, 1'b0);
    rfw(5'h1C, 8'h00, 1'b0);
    rfw(5'h1D, 8'h02, 1'b0);
    rfw(5'h1E, 8'h34, 1'b0);
    rfw(5'h1F, 8'h12, 1'b0);
    @(posedge clk);
    ptr_req <= '{1'b1, 2'h0, regfile_guard_pkg::PTR_POST_INC, 6'h00};
    @(posedge clk);
    ptr_req <= '{1'b1, 2'h1, regfile_guard_pkg::PTR_PRE_DEC, 6'h00};
    #1 chk("x_addr", ptr_addr, 16'h01FF);
    @(posedge clk);
    ptr_req <= '{1'b1, 2'h2, regfile_guard_pkg::PTR_DISP, 6'h3F};
    #1 chk("y_addr", ptr_addr, 16'h01FF);
    @(posedge clk);
    ptr_req <= '0;
    #1 chk("z_addr", ptr_addr, 16'h1273);
    look(5'h1A, 5'h1B, 1'b0);
    chk("x_inc", {rd_b_data, rd_a_data}, 16'h0200);
    look(5'h1C, 5'h1D, 1'b0);
    chk("y_dec", {rd_b_data, rd_a_data}, 16'h01FF);
    chk("prog_ptr", prog_ptr_addr, 16'h1234);
    rfw(5'h1F, 8'h56, 1'b0);
    repeat (3) @(posedge clk);
    #1 chk("alias", prog_ptr_addr, 16'h5634);
    $display("done regs");
  endtask : t_regs
  // -------------------------------------------------
  // run control
  // -------------------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {rd_a_idx, rd_b_idx, rd_a_imm_op} = '0;
    rf_wr = '0;
    ptr_req = '0;
    ev_req = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_wide();
    t_guard();
    t_burst();
    t_regs();
    end_sim();
  end
endmodule : tb_cpu_regfile_wide_access_guard
